// *** rtl/ldm_laser_mod_ctrl.sv ***
// Modulation DAC code control, deemphasis, equaliser select and eye-safety alarms
//
// Overview of operation
// - Nine-bit modulation code; setting register writes its upper eight bits directly.
// - Code bit 0 is zero after reset and changes only through step writes.
// - Ceiling register bounds the upper eight code bits.
// - Step register low five bits, two's complement -16..+15, added on write.
// - Step exceeding ceiling sets limit warning and leaves the code unchanged.
// - Equaliser enable clear bypasses equaliser and ignores profile select.
// - Enabled equaliser uses two-bit profile: trace length and source amplitude.
// - Delivered drive is the code current minus the deemphasis current.
// - Deemphasis set by control bits 5:4 and the six-bit amount field.
// - Laser currents stay off while power-on reset is active.
// - After reset, drive ramps toward the programmed code without overshoot.
// - Every power-on reset returns all registers to defaults.
// - Bias limit comparator tripping latches an alarm.
// - Shutdown pin or cleared enable bit gates the laser off.
// - Shutdown-class alarm asserts the alarm pin and disables the laser.
// - Warning-class alarm is only reported; laser stays enabled.
// - Both alarm classes are recorded in the two status registers.
// - Alarm pin stays latched until the shutdown pin is toggled.
// - Toggling the shutdown pin clears both status registers.
// - Shutdown pin high disables output; low leaves it to enable and alarms.
// - Deemphasis mode 00 6.25%, 01 3.125%, 10 amount field, 11 about 9%.
// - Modulation limit warning is sticky bit 3 of the second status register.
`timescale 1ns/10ps
`default_nettype none
module ldm_laser_mod_ctrl
    import ldm_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [6:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       shutdown_pin,
    input  wire logic       bias_limit_sense,
    input  wire logic       out_low_sense,
    input  wire logic       bias_low_sense,
    input  wire logic       monitor_high_sense,
    input  wire logic       out_cm_low_sense,
    input  wire logic       input_absent,
    output logic [7:0]      reg_rdata,
    output logic            reg_rvalid,
    output logic [8:0]      mod_dac_code,
    output logic [8:0]      mod_drive_code,
    output logic [7:0]      deemph_weight,
    output logic            laser_on,
    output logic            input_eq_on,
    output logic [1:0]      input_eq_profile,
    output logic            polarity_normal,
    output logic            alarm_pin_out,
    output logic            alarm_pin_oe
);
    ldm_regs_t  st;
    ldm_regs_t  next_st;
    logic [9:0] step_cand;
    logic       step_below;
    logic       step_over;
    logic       shut_fall;
    logic       hard_now;
    logic [7:0] ev_one;
    logic [7:0] ev_two;

    // Saturating min used by direct writes and by the direct-write check
    function automatic logic [7:0] ldm_min8(input logic [7:0] a, input logic [7:0] b);
        ldm_min8 = (a < b) ? a : b;
    endfunction : ldm_min8

    // Step candidate; a 10-bit sum exposes both underflow and overflow
    assign step_cand  = {1'b0, st.code} + {{5{reg_wdata[4]}}, reg_wdata[4:0]};
    assign step_below = reg_wdata[4] & step_cand[9];
    assign step_over  = ~reg_wdata[4] & (step_cand[9] | (step_cand[8:1] > st.ceiling));
    assign shut_fall  = st.shut_prev & ~shutdown_pin;
    assign hard_now   = bias_limit_sense | out_low_sense | bias_low_sense;

    // Alarm events this cycle, laid out as the status registers
    always_comb begin
        ev_one = 8'h00;
        ev_two = 8'h00;
        ev_one[ST1_BIAS_LIM] = bias_limit_sense;
        ev_one[ST1_OUT_LOW]  = out_low_sense;
        ev_one[ST1_BIAS_LOW] = bias_low_sense;
        ev_one[ST1_MON_HIGH] = monitor_high_sense;
        ev_one[ST1_CM_LOW]   = out_cm_low_sense;
        ev_one[ST1_FAULT]    = hard_now | monitor_high_sense | out_cm_low_sense;
        ev_two[ST2_IN_ABS]   = input_absent;
        ev_two[ST2_MOD_WARN] = reg_wr && reg_addr == ADDR_MOD_STEP && step_over;
    end

    // Next-state logic for the whole block
    always_comb begin
        logic        gate;
        logic [16:0] prod;
        logic [8:0]  target;
        next_st = st;
        gate    = 1'b0;
        prod    = 17'h00000;
        target  = 9'h000;
        next_st.rd_valid  = 1'b0;
        next_st.shut_prev = shutdown_pin;

        // Register writes; status registers are read-only
        if (reg_wr) begin
            if (reg_addr == ADDR_TX_CTRL) begin
                next_st.tx_ctrl = reg_wdata[5:0];
            end else if (reg_addr == ADDR_MOD_SET) begin
                next_st.code[8:1] = ldm_min8(reg_wdata, st.ceiling);
            end else if (reg_addr == ADDR_MOD_CEIL) begin
                next_st.ceiling = reg_wdata;
            end else if (reg_addr == ADDR_MOD_STEP) begin
                next_st.step = reg_wdata;
                if (!step_below && !step_over) begin
                    next_st.code = step_cand[8:0];
                end
            end else if (reg_addr == ADDR_DEEMPH) begin
                next_st.deemph_amount = reg_wdata[5:0];
            end else if (reg_addr == ADDR_EQ) begin
                next_st.eq_profile = reg_wdata[2:1];
            end
        end

        // Register reads, answered one cycle later
        if (reg_rd) begin
            next_st.rd_valid = 1'b1;
            if (reg_addr == ADDR_TX_CTRL) begin
                next_st.rd_data = {2'b00, st.tx_ctrl};
            end else if (reg_addr == ADDR_STAT_ONE) begin
                next_st.rd_data = st.stat_one;
            end else if (reg_addr == ADDR_STAT_TWO) begin
                next_st.rd_data = st.stat_two;
            end else if (reg_addr == ADDR_MOD_SET) begin
                next_st.rd_data = st.code[8:1];
            end else if (reg_addr == ADDR_MOD_CEIL) begin
                next_st.rd_data = st.ceiling;
            end else if (reg_addr == ADDR_MOD_STEP) begin
                next_st.rd_data = st.step;
            end else if (reg_addr == ADDR_DEEMPH) begin
                next_st.rd_data = {2'b00, st.deemph_amount};
            end else if (reg_addr == ADDR_EQ) begin
                next_st.rd_data = {5'b00000, st.eq_profile, 1'b0};
            end else begin
                next_st.rd_data = 8'h00;
            end
        end

        // Sticky status and alarm latch; a new event beats a toggle clear
        if (shut_fall) begin
            next_st.stat_one      = ev_one;
            next_st.stat_two      = ev_two;
            next_st.alarm_latched = hard_now;
        end else begin
            next_st.stat_one      = st.stat_one | ev_one;
            next_st.stat_two      = st.stat_two | ev_two;
            next_st.alarm_latched = st.alarm_latched | hard_now;
        end
        // Open drain: released (high) means alarm, driven low means none
        next_st.alarm_oe = ~next_st.alarm_latched;

        // Laser gate: enable bit, shutdown pin and latched alarm
        gate = st.tx_ctrl[TXC_EN_BIT] & ~shutdown_pin & ~st.alarm_latched;
        next_st.laser_on = gate;
        target = st.code;

        // Soft start; rising is paced, falling is immediate since it is safe
        case (st.state)
            LDM_OFF: begin
                next_st.dac      = 9'h000;
                next_st.ramp_cnt = RAMP_CYCLES;
                if (gate) begin
                    next_st.state = LDM_RAMP;
                end
            end
            LDM_RAMP: begin
                if (!gate) begin
                    next_st.state = LDM_OFF;
                    next_st.dac   = 9'h000;
                end else if (st.dac >= target) begin
                    next_st.dac   = target;
                    next_st.state = LDM_RUN;
                end else if (st.ramp_cnt == 8'h00) begin
                    next_st.dac      = st.dac + 9'h001;
                    next_st.ramp_cnt = RAMP_CYCLES;
                end else begin
                    next_st.ramp_cnt = st.ramp_cnt - 8'h01;
                end
            end
            LDM_RUN: begin
                if (!gate) begin
                    next_st.state = LDM_OFF;
                    next_st.dac   = 9'h000;
                end else if (target > st.dac) begin
                    next_st.state    = LDM_RAMP;
                    next_st.ramp_cnt = RAMP_CYCLES;
                end else begin
                    next_st.dac = target;
                end
            end
            default: begin
                next_st.state = LDM_OFF;
                next_st.dac   = 9'h000;
            end
        endcase

        // Deemphasis weight by mode
        case (st.tx_ctrl[TXC_DE_LSB +: 2])
            2'b00:   next_st.weight = DE_W_MODE0;
            2'b01:   next_st.weight = DE_W_MODE1;
            2'b10:   next_st.weight = {2'b00, st.deemph_amount};
            default: next_st.weight = DE_W_MODE3;
        endcase
        // Delivered drive: code minus the deemphasised share
        prod = st.dac * st.weight;
        next_st.drive = st.dac - prod[16:8];

        // Equaliser profile only counts while enabled
        next_st.eq_on  = st.tx_ctrl[TXC_EQ_BIT];
        next_st.eq_sel = st.tx_ctrl[TXC_EQ_BIT] ? st.eq_profile : 2'b00;
        next_st.pol_normal = st.tx_ctrl[TXC_POL_BIT];
    end

    // Whole state in one register; reset holds the laser off
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st <= LDM_REGS_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register, except alarm_pin_out tied low
    assign reg_rdata        = st.rd_data;
    assign reg_rvalid       = st.rd_valid;
    assign mod_dac_code     = st.dac;
    assign mod_drive_code   = st.drive;
    assign deemph_weight    = st.weight;
    assign laser_on         = st.laser_on;
    assign input_eq_on      = st.eq_on;
    assign input_eq_profile = st.eq_sel;
    assign polarity_normal  = st.pol_normal;
    assign alarm_pin_out    = 1'b0;
    assign alarm_pin_oe     = st.alarm_oe;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_alarm_off;
        st.alarm_latched |=> !laser_on && mod_dac_code == 9'h000;
    endproperty
    a_alarm_off: assert property (p_alarm_off) else $error("laser on with alarm");

    property p_shut_pin;
        shutdown_pin |=> !laser_on ##1 mod_dac_code == 9'h000;
    endproperty
    a_shut_pin: assert property (p_shut_pin) else $error("laser on with shutdown");

    property p_enable_bit;
        !st.tx_ctrl[TXC_EN_BIT] |=> !laser_on;
    endproperty
    a_enable_bit: assert property (p_enable_bit) else $error("laser on with enable clear");

    property p_bias_trip;
        bias_limit_sense |=> st.alarm_latched && !alarm_pin_oe && st.stat_one[ST1_BIAS_LIM];
    endproperty
    a_bias_trip: assert property (p_bias_trip) else $error("bias limit not latched");

    property p_latch_hold;
        st.alarm_latched && !shut_fall |=> st.alarm_latched && !alarm_pin_oe;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("alarm dropped");

    property p_toggle_clear;
        shut_fall && ev_one == 8'h00 && ev_two == 8'h00
            |=> st.stat_one == 8'h00 && st.stat_two == 8'h00 && alarm_pin_oe;
    endproperty
    a_toggle_clear: assert property (p_toggle_clear) else $error("toggle did not clear");

    property p_soft_keeps;
        st.tx_ctrl[TXC_EN_BIT] && !shutdown_pin && !st.alarm_latched && !hard_now
            |=> laser_on;
    endproperty
    a_soft_keeps: assert property (p_soft_keeps) else $error("warning disabled laser");

    property p_step_reject;
        reg_wr && reg_addr == ADDR_MOD_STEP && (step_over || step_below)
            |=> $stable(st.code);
    endproperty
    a_step_reject: assert property (p_step_reject) else $error("rejected step changed code");

    property p_step_warn;
        reg_wr && reg_addr == ADDR_MOD_STEP && step_over && !shut_fall
            |=> st.stat_two[ST2_MOD_WARN] ##1 st.stat_two[ST2_MOD_WARN] || $past(shut_fall);
    endproperty
    a_step_warn: assert property (p_step_warn) else $error("limit warning missing");

    property p_step_ok;
        logic [8:0] c;
        (reg_wr && reg_addr == ADDR_MOD_STEP && !step_over && !step_below, c = step_cand[8:0])
            |=> st.code == c;
    endproperty
    a_step_ok: assert property (p_step_ok) else $error("step not applied");

    property p_set_lsb;
        reg_wr && reg_addr == ADDR_MOD_SET
            |=> st.code[0] == $past(st.code[0])
                && st.code[8:1] == ldm_min8($past(reg_wdata), $past(st.ceiling));
    endproperty
    a_set_lsb: assert property (p_set_lsb) else $error("direct write wrong");

    property p_ramp_rate;
        mod_dac_code > $past(mod_dac_code) |-> mod_dac_code == $past(mod_dac_code) + 9'h001;
    endproperty
    a_ramp_rate: assert property (p_ramp_rate) else $error("ramp jumped");

    property p_eq_bypass;
        !st.tx_ctrl[TXC_EQ_BIT] |=> !input_eq_on && input_eq_profile == 2'b00;
    endproperty
    a_eq_bypass: assert property (p_eq_bypass) else $error("equaliser not bypassed");

    property p_deemph_mode;
        st.tx_ctrl[TXC_DE_LSB +: 2] == 2'b01 |=> deemph_weight == DE_W_MODE1;
    endproperty
    a_deemph_mode: assert property (p_deemph_mode) else $error("deemphasis weight wrong");

    // A rising step may only follow an expired pacing counter
    property p_ramp_pace;
        mod_dac_code > $past(mod_dac_code) |-> $past(st.ramp_cnt) == 8'h00;
    endproperty
    a_ramp_pace: assert property (p_ramp_pace) else $error("ramp step too early");

    // Warning-class events alone never latch the alarm pin
    property p_warn_no_latch;
        (monitor_high_sense || out_cm_low_sense || input_absent) && !hard_now
            && !st.alarm_latched |=> !st.alarm_latched && alarm_pin_oe;
    endproperty
    a_warn_no_latch: assert property (p_warn_no_latch) else $error("warning latched alarm");

    c_ramp_done: cover property (st.state == LDM_RAMP ##1 st.state == LDM_RUN);
    c_step_over: cover property (reg_wr && reg_addr == ADDR_MOD_STEP && step_over);
    c_alarm_clr: cover property (st.alarm_latched ##1 shut_fall ##1 !st.alarm_latched);
    c_step_below: cover property (reg_wr && reg_addr == ADDR_MOD_STEP && step_below);
    c_hard_trip: cover property (hard_now ##1 !alarm_pin_oe ##1 !laser_on);
endmodule : ldm_laser_mod_ctrl
`default_nettype wire

// *** rtl/ldm_pkg.sv ***
// Constants, register map and state types of the laser modulation control block
package ldm_pkg;
    // Register addresses on the serial control port
    localparam logic [6:0] ADDR_TX_CTRL  = 7'h05;
    localparam logic [6:0] ADDR_STAT_ONE = 7'h06;
    localparam logic [6:0] ADDR_STAT_TWO = 7'h07;
    localparam logic [6:0] ADDR_MOD_SET  = 7'h09;
    localparam logic [6:0] ADDR_MOD_CEIL = 7'h0A;
    localparam logic [6:0] ADDR_MOD_STEP = 7'h0C;
    localparam logic [6:0] ADDR_DEEMPH   = 7'h10;
    localparam logic [6:0] ADDR_EQ       = 7'h11;
    // Field positions in the transmit control register
    localparam int unsigned TXC_EN_BIT  = 0;
    localparam int unsigned TXC_POL_BIT = 1;
    localparam int unsigned TXC_EQ_BIT  = 3;
    localparam int unsigned TXC_DE_LSB  = 4;
    // Field positions in the two status registers
    localparam int unsigned ST1_MON_HIGH = 6;
    localparam int unsigned ST1_BIAS_LIM = 4;
    localparam int unsigned ST1_CM_LOW   = 3;
    localparam int unsigned ST1_OUT_LOW  = 2;
    localparam int unsigned ST1_BIAS_LOW = 1;
    localparam int unsigned ST1_FAULT    = 0;
    localparam int unsigned ST2_MOD_WARN = 3;
    localparam int unsigned ST2_IN_ABS   = 1;
    // Values after reset
    localparam logic [7:0] TX_CTRL_RESET = 8'h03;
    localparam logic [8:0] MOD_CODE_RESET = 9'h000;
    localparam logic [7:0] CEIL_RESET    = 8'h00;
    localparam logic [7:0] STEP_RESET    = 8'h00;
    localparam logic [5:0] DEEMPH_RESET  = 6'h00;
    localparam logic [1:0] EQ_RESET      = 2'h0;
    // Deemphasis weights in 1/256 of the modulation code
    localparam logic [7:0] DE_W_MODE0 = 8'h10;
    localparam logic [7:0] DE_W_MODE1 = 8'h08;
    localparam logic [7:0] DE_W_MODE3 = 8'h17;
    // Ramp pacing: one code step per RAMP_CYCLES + 1 clocks, the count being the interval rounded up
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned RAMP_STEP_NS  = 100;
    localparam logic [7:0] RAMP_CYCLES =
        8'((RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        LDM_OFF  = 3'b001,
        LDM_RAMP = 3'b010,
        LDM_RUN  = 3'b100
    } ldm_state_t;

    typedef struct packed {
        ldm_state_t  state;
        logic [7:0]  ramp_cnt;
        logic [8:0]  code;
        logic [7:0]  ceiling;
        logic [7:0]  step;
        logic [5:0]  tx_ctrl;
        logic [5:0]  deemph_amount;
        logic [1:0]  eq_profile;
        logic [7:0]  stat_one;
        logic [7:0]  stat_two;
        logic        alarm_latched;
        logic        shut_prev;
        logic [8:0]  dac;
        logic [8:0]  drive;
        logic [7:0]  weight;
        logic        laser_on;
        logic        eq_on;
        logic [1:0]  eq_sel;
        logic        pol_normal;
        logic        alarm_oe;
        logic [7:0]  rd_data;
        logic        rd_valid;
    } ldm_regs_t;

    localparam ldm_regs_t LDM_REGS_RESET = '{
        state: LDM_OFF, ramp_cnt: 8'h00, code: MOD_CODE_RESET,
        ceiling: CEIL_RESET, step: STEP_RESET, tx_ctrl: TX_CTRL_RESET[5:0],
        deemph_amount: DEEMPH_RESET, eq_profile: EQ_RESET, stat_one: 8'h00,
        stat_two: 8'h00, alarm_latched: 1'b0, shut_prev: 1'b1, dac: 9'h000,
        drive: 9'h000, weight: DE_W_MODE0, laser_on: 1'b0, eq_on: 1'b0,
        eq_sel: 2'h0, pol_normal: 1'b1, alarm_oe: 1'b1, rd_data: 8'h00,
        rd_valid: 1'b0};
endpackage : ldm_pkg

// *** verification/ldm_ctrl_model.sv ***
// Controller model: register strobes and shutdown pin of the module controller
`timescale 1ns/10ps
`default_nettype none
module ldm_ctrl_model (
    input  wire logic       clock,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [6:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            shutdown_pin,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    // Idle bus; pin high as if left floating, so the laser starts gated
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h7F;
        reg_wdata = 8'hA5;
        shutdown_pin = 1'b1;
    end

    // One-cycle write; address and data inverted afterwards so stale values never match
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clock);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    // One-cycle read; data taken just after the edge that raises the valid pulse
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
        @(posedge clock);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clock);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
        v = reg_rvalid;
    endtask : rd

    // Pin level; high then low gives the clearing toggle
    task automatic set_pin(input logic lvl);
        @(posedge clock);
        #1;
        shutdown_pin = lvl;
    endtask : set_pin
endmodule : ldm_ctrl_model
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the laser modulation control block
`timescale 1ns/10ps
`default_nettype none
module tb
    import ldm_pkg::*;
;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [5:0] sense = 6'h00;
    logic reg_wr, reg_rd, shutdown_pin, reg_rvalid, laser_on, input_eq_on;
    logic polarity_normal, alarm_pin_out, alarm_pin_oe;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, deemph_weight, d;
    logic [8:0] mod_dac_code, mod_drive_code;
    logic [1:0] input_eq_profile;
    int err_count = 0;
    int total_checks = 0;
    int code, ceil, warn, w, amt, over, msk, hard;
    int steps[3] = '{15, -16, 15};

    always #5 clock = ~clock;

    ldm_laser_mod_ctrl dut_u (.clock(clock), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .shutdown_pin(shutdown_pin),
        .bias_limit_sense(sense[0]), .out_low_sense(sense[1]), .bias_low_sense(sense[2]),
        .monitor_high_sense(sense[3]), .out_cm_low_sense(sense[4]), .input_absent(sense[5]),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .mod_dac_code(mod_dac_code),
        .mod_drive_code(mod_drive_code), .deemph_weight(deemph_weight), .laser_on(laser_on),
        .input_eq_on(input_eq_on), .input_eq_profile(input_eq_profile),
        .polarity_normal(polarity_normal), .alarm_pin_out(alarm_pin_out),
        .alarm_pin_oe(alarm_pin_oe));
    ldm_ctrl_model ctl (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .shutdown_pin(shutdown_pin), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    task automatic check(input logic [15:0] seen, input int exp, input string msg);
        total_checks++;
        if (seen !== 16'(exp)) begin
            err_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, 16'(exp));
        end
    endtask : check

    // Read; a missing valid pulse turns the data unknown so it can never match
    task automatic rdv(input logic [6:0] a);
        logic v;
        ctl.rd(a, d, v);
        if (v !== 1'b1) d = 8'hxx;
    endtask : rdv

    task automatic settle();
        repeat (4) @(posedge clock);
        #1;
    endtask : settle

    // Model: candidate is code plus step, committed only within floor and ceiling
    task automatic step(input int s);
        int cand;
        cand = code + s;
        ctl.wr(ADDR_MOD_STEP, 8'(s & 31));
        if (cand >= 0 && (cand >> 1) <= ceil) code = cand;
        else if (cand >= 0) warn = 1;
        rdv(ADDR_MOD_SET);
        check(d, code >> 1, "stepped setting");
        rdv(ADDR_STAT_TWO);
        check(d[3], warn, "limit warning");
    endtask : step

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // Watchdog about ten times the expected run of some 2000 cycles
    initial begin
        #200_000;
        err_count++;
        final_report();
    end

    initial begin
        void'($urandom(32));
        repeat (6) @(posedge clock);
        #1;
        rst_b = 1'b1;
        rdv(ADDR_TX_CTRL);
        check(d, 8'h03, "control default");
        rdv(7'h01);
        check(d, 0, "unmapped read");
        ctl.wr(ADDR_STAT_ONE, 8'hFF);
        rdv(ADDR_STAT_ONE);
        check(d, 0, "status write ignored");
        $display("test registers done");
        // Steps against the ceiling, fixed boundary cases then random ones
        ceil = 8'h60;
        code = 9'h0BE;
        warn = 0;
        ctl.wr(ADDR_MOD_CEIL, 8'h60);
        ctl.wr(ADDR_MOD_SET, 8'h5F);
        ctl.set_pin(1'b0);
        foreach (steps[i]) step(steps[i]);
        repeat (16) step(int'($urandom_range(31)) - 16);
        ctl.wr(ADDR_MOD_SET, 8'h00);
        code = code & 1;
        step(-16);
        ctl.wr(ADDR_MOD_SET, 8'h50);
        code = 9'h0A0 | (code & 1);
        over = 0;
        for (int i = 0; i < 3000 && mod_dac_code !== 9'(code); i++) begin
            @(posedge clock);
            #1;
            if (mod_dac_code > code) over = 1;
        end
        check(mod_dac_code, code, "ramped code");
        check(over, 0, "ramp overshoot");
        $display("test modulation code done");
        // Every deemphasis mode with a random amount
        for (int m = 0; m < 4; m++) begin
            amt = $urandom_range(63);
            ctl.wr(ADDR_DEEMPH, 8'(amt));
            ctl.wr(ADDR_TX_CTRL, 8'(3 + 16 * m));
            w = (m == 0) ? DE_W_MODE0 : (m == 1) ? DE_W_MODE1 : (m == 2) ? amt : DE_W_MODE3;
            settle();
            check(deemph_weight, w, "deemphasis weight");
            check(mod_drive_code, code - ((code * w) >> 8), "drive");
        end
        // Equaliser enable, profiles and polarity
        for (int k = 0; k < 8; k++) begin
            ctl.wr(ADDR_EQ, 8'((k % 4) * 2));
            ctl.wr(ADDR_TX_CTRL, 8'(1 + 2 * (k % 2) + 8 * (k / 4)));
            settle();
            check(input_eq_on, k / 4, "equaliser on");
            check(input_eq_profile, (k / 4) * (k % 4), "profile");
            check(polarity_normal, k % 2, "polarity");
        end
        ctl.wr(ADDR_TX_CTRL, 8'h02);
        settle();
        check(laser_on, 0, "enable bit clear");
        ctl.wr(ADDR_TX_CTRL, 8'h03);
        $display("test output control done");
        // Each alarm source: pulse, latch, class behaviour, then clear by toggle
        for (int i = 0; i < 6; i++) begin
            ctl.set_pin(1'b1);
            ctl.set_pin(1'b0);
            check(laser_on, 0, "pin high gates laser");
            settle();
            check(alarm_pin_oe, 1, "alarm cleared");
            check(laser_on, 1, "laser back on");
            hard = (i < 3);
            msk = (i == 0) ? 17 : (i == 1) ? 5 : (i == 2) ? 3 : (i == 3) ? 65 : (i == 4) ? 9 : 2;
            sense[i] = 1'b1;
            @(posedge clock);
            #1;
            sense[i] = 1'b0;
            @(posedge clock);
            #1;
            check({alarm_pin_out, alarm_pin_oe}, !hard, "alarm pin");
            @(posedge clock);
            #1;
            check(laser_on, !hard, "laser after alarm");
            rdv(i < 5 ? ADDR_STAT_ONE : ADDR_STAT_TWO);
            check(d & msk, msk, "status recorded");
            check(alarm_pin_oe, !hard, "alarm still latched");
        end
        ctl.set_pin(1'b1);
        ctl.set_pin(1'b0);
        settle();
        rdv(ADDR_STAT_ONE);
        check(d, 0, "status one cleared");
        rdv(ADDR_STAT_TWO);
        check(d, 0, "status two cleared");
        $display("test alarms done");
        // Second reset in mid-run
        @(posedge clock);
        #1;
        rst_b = 1'b0;
        #1;
        check({laser_on, alarm_pin_oe, mod_dac_code}, 16'h0200, "outputs in reset");
        check(deemph_weight, DE_W_MODE0, "weight in reset");
        repeat (6) @(posedge clock);
        #1;
        rst_b = 1'b1;
        rdv(ADDR_MOD_SET);
        check(d, 0, "setting after reset");
        rdv(ADDR_MOD_CEIL);
        check(d, 0, "ceiling after reset");
        $display("test reset done");
        final_report();
    end
endmodule : tb
`default_nettype wire
